/* cmid_decode.sv */
// Group-one instruction decoder: form, size, register selects and gating.
// Assumes one instruction word per instr_valid_in strobe, condition result
// supplied in the same cycle; outputs follow one clock later for one cycle.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// RULE1 - False condition suppresses compute and move
// RULE2 - No condition means always execute
// RULE3 - Variant a/b/c are 48/32/16 bits
// RULE4 - First index field selects I7-I0
// RULE5 - First modify field selects M7-M0
// RULE6 - Second index field selects I15-I8
// RULE7 - Second modify field selects M15-M8
// RULE8 - Data field selects R15-R0
// RULE9 - Complement field selects S15-S0
// RULE10 - Long word qualifier forces long access
// RULE11 - Second element increment follows operating mode
// RULE12 - Compute runs beside the data move
// RULE13 - Form 1a: compute plus dual move
// RULE14 - Form 1b: dual move, no compute
// RULE15 - Form 3c: data memory only, bare
// RULE16 - Form 4: six-bit immediate modifier
// RULE17 - Form 5: register move or swap
// RULE18 - Form 6: shift immediate plus move
// RULE19 - Form 7: index modify or write
// RULE20 - Pre-modify or post-modify with write-back
// RULE21 - SIMD index plus one, broadcast unchanged (the code uses plus two for SIMD short word access)
// RULE22 - Unlisted encodings flagged, executed as no-op
// RULE23 - False condition also blocks write-back
module cmid_decode (
   // Clock and reset
   input  wire logic                       clk_in,
   input  wire logic                       sys_rst_in,
   // Instruction from the sequencer
   input  wire logic                       instr_valid_in,
   input  wire logic [cmid_pkg::CMID_WORD_W-1:0] instr_word_in,
   input  wire logic                       cond_true_in,
   // Operating mode
   input  wire cmid_pkg::cmid_mode_e       mode_in,
   input  wire logic                       short_word_in,
   // Decoded control
   output logic                            valid_out,
   output logic                            exec_out,
   output logic                            illegal_out,
   output cmid_pkg::cmid_size_e            size_out,
   output logic                            compute_en_out,
   output logic                            shift_imm_en_out,
   // Memory ports
   output logic                            dm_en_out,
   output logic                            dm_wr_out,
   output logic                            pm_en_out,
   output logic                            pm_wr_out,
   output logic [3:0]                      dm_index_out,
   output logic [3:0]                      dm_modify_out,
   output logic [3:0]                      pm_index_out,
   output logic [3:0]                      pm_modify_out,
   output logic                            long_word_out,
   output logic                            pre_mod_out,
   output logic                            wb_dm_out,
   output logic                            wb_pm_out,
   output logic                            imm_mod_en_out,
   output logic [5:0]                      imm_mod_out,
   // Register file
   output logic [3:0]                      dreg_a_out,
   output logic [3:0]                      dreg_b_out,
   output logic [1:0]                      y_incr_out,
   output logic                            reg_move_out,
   output logic                            swap_out,
   output logic                            index_write_out
);
   import cmid_pkg::*;

   cmid_state_s st;
   cmid_state_s next_st;

   logic [2:0] f_form;
   logic [1:0] f_var;
   logic       f_condp;
   logic       f_compp;
   logic       f_selpm;
   logic       f_long;
   logic       legal;
   logic       cond_ok;
   logic       go;

   // Absolute register number: generator half in the msb
   function automatic logic [3:0] reg_num(input logic hi, input logic [2:0] sel);
      reg_num = {hi, sel};
   endfunction

   // Size code of a variant letter
   function automatic cmid_size_e size_of(input logic [1:0] v);
      unique case (v)
         CMID_VAR_A: size_of = CMID_SZ_48;
         CMID_VAR_B: size_of = CMID_SZ_32;
         CMID_VAR_C: size_of = CMID_SZ_16;
         default:    size_of = CMID_SZ_NONE;
      endcase
   endfunction

   // Header fields
   assign f_form  = instr_word_in[CMID_F_FORM +: 3];
   assign f_var   = instr_word_in[CMID_F_VAR +: 2];
   assign f_condp = instr_word_in[CMID_F_CONDP];
   assign f_compp = instr_word_in[CMID_F_COMPP];
   assign f_selpm = instr_word_in[CMID_F_SELPM];
   assign f_long  = instr_word_in[CMID_F_LONG];

   // RULE22 legal form check
   always_comb begin
      legal = 1'b0;
      unique case (f_form)
         CMID_FORM1: legal = (f_var == CMID_VAR_A) || (f_var == CMID_VAR_B && !f_compp);
         CMID_FORM2: legal = (f_var == CMID_VAR_A) || ((f_var != 2'h3) && !f_condp);
         CMID_FORM3: legal = (f_var == CMID_VAR_A) || (f_var == CMID_VAR_B && !f_compp)
                             || (f_var == CMID_VAR_C && !f_compp && !f_condp && !f_selpm && !f_long);
         CMID_FORM4,
         CMID_FORM5,
         CMID_FORM7: legal = (f_var == CMID_VAR_A) || (f_var == CMID_VAR_B && !f_compp);
         CMID_FORM6: legal = (f_var == CMID_VAR_A);
         default:    legal = 1'b0;
      endcase
   end

   // RULE1 RULE2 condition gating
   assign cond_ok = !f_condp || cond_true_in;
   assign go      = instr_valid_in && legal && cond_ok;

   // Decode one instruction; every enable is qualified by go so a false
   // condition or an unlisted encoding leaves no side effect at all
   always_comb begin
      next_st         = CMID_STATE_RST;
      next_st.valid   = instr_valid_in;
      next_st.exec    = go;
      // RULE22 flag unlisted encodings
      next_st.illegal = instr_valid_in && !legal;
      // RULE3 size from variant
      next_st.size    = instr_valid_in ? size_of(f_var) : CMID_SZ_NONE;
      // RULE4 RULE5 RULE6 RULE7 generator register selects
      next_st.dm_index  = reg_num(1'b0, instr_word_in[CMID_F_G1I +: 3]);
      next_st.dm_modify = reg_num(1'b0, instr_word_in[CMID_F_G1M +: 3]);
      next_st.pm_index  = reg_num(1'b1, instr_word_in[CMID_F_G2I +: 3]);
      next_st.pm_modify = reg_num(1'b1, instr_word_in[CMID_F_G2M +: 3]);
      // RULE8 RULE9 data and complementary register numbers
      next_st.dreg_a = instr_word_in[CMID_F_DRA +: 4];
      next_st.dreg_b = instr_word_in[CMID_F_DRB +: 4];
      // RULE11 RULE21 second element address offset
      unique case (mode_in)
         CMID_SIMD: next_st.y_incr = short_word_in ? CMID_YINC_SHORT : CMID_YINC_NORM;
         default:   next_st.y_incr = 2'h0;
      endcase
      // RULE23 write-back needs go
      if (go) begin
         // RULE12 compute beside the move
         next_st.compute_en = f_compp && (f_form != CMID_FORM6);
         unique case (f_form)
            // RULE13 RULE14 dual move, both post-modified
            CMID_FORM1: begin
               next_st.dm_en = 1'b1;
               next_st.pm_en = 1'b1;
               next_st.dm_wr = instr_word_in[CMID_F_DMWR];
               next_st.pm_wr = instr_word_in[CMID_F_PMWR];
               next_st.wb_dm = 1'b1;
               next_st.wb_pm = 1'b1;
            end
            CMID_FORM2: begin
               next_st.compute_en = 1'b1;
            end
            // RULE15 RULE16 RULE20 single move, modify register or immediate
            CMID_FORM3,
            CMID_FORM4,
            CMID_FORM6: begin
               next_st.dm_en   = !f_selpm;
               next_st.pm_en   = f_selpm;
               next_st.dm_wr   = !f_selpm && instr_word_in[CMID_F_DMWR];
               next_st.pm_wr   = f_selpm && instr_word_in[CMID_F_DMWR];
               next_st.pre_mod = instr_word_in[CMID_F_PRE] && (f_form != CMID_FORM6);
               next_st.wb_dm   = !f_selpm && !next_st.pre_mod;
               next_st.wb_pm   = f_selpm && !next_st.pre_mod;
               // RULE10 long word override
               next_st.long_word = f_long && (f_form == CMID_FORM3);
               if (f_form == CMID_FORM4) begin
                  next_st.imm_mod_en = 1'b1;
                  next_st.imm_mod    = instr_word_in[CMID_F_IMM +: 6];
               end
               // RULE18 shift immediate replaces compute
               next_st.shift_imm_en = (f_form == CMID_FORM6);
            end
            // RULE17 register transfer or swap
            CMID_FORM5: begin
               next_st.reg_move = !instr_word_in[CMID_F_SWAP];
               next_st.swap     = instr_word_in[CMID_F_SWAP];
            end
            // RULE19 index modify with update or named destination
            CMID_FORM7: begin
               next_st.index_write = instr_word_in[CMID_F_IWR];
               next_st.wb_dm       = !f_selpm && !instr_word_in[CMID_F_IWR];
               next_st.wb_pm       = f_selpm && !instr_word_in[CMID_F_IWR];
            end
            default: begin
               next_st.compute_en = 1'b0;
            end
         endcase
      end
   end

   // State register; cleared asynchronously
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         st <= CMID_STATE_RST;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the state register
   assign valid_out        = st.valid;
   assign exec_out         = st.exec;
   assign illegal_out      = st.illegal;
   assign size_out         = st.size;
   assign compute_en_out   = st.compute_en;
   assign shift_imm_en_out = st.shift_imm_en;
   assign dm_en_out        = st.dm_en;
   assign dm_wr_out        = st.dm_wr;
   assign pm_en_out        = st.pm_en;
   assign pm_wr_out        = st.pm_wr;
   assign dm_index_out     = st.dm_index;
   assign dm_modify_out    = st.dm_modify;
   assign pm_index_out     = st.pm_index;
   assign pm_modify_out    = st.pm_modify;
   assign long_word_out    = st.long_word;
   assign pre_mod_out      = st.pre_mod;
   assign wb_dm_out        = st.wb_dm;
   assign wb_pm_out        = st.wb_pm;
   assign imm_mod_en_out   = st.imm_mod_en;
   assign imm_mod_out      = st.imm_mod;
   assign dreg_a_out       = st.dreg_a;
   assign dreg_b_out       = st.dreg_b;
   assign y_incr_out       = st.y_incr;
   assign reg_move_out     = st.reg_move;
   assign swap_out         = st.swap;
   assign index_write_out  = st.index_write;

   // Checks on the decoded outputs
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   property p_cond_false;
      instr_valid_in && f_condp && !cond_true_in |=> !exec_out && !dm_en_out && !pm_en_out && !compute_en_out;
   endproperty
   a_cond_false: assert property (p_cond_false) else $error("false condition executed"); // RULE1

   property p_uncond;
      instr_valid_in && !f_condp && legal |=> exec_out;
   endproperty
   a_uncond: assert property (p_uncond) else $error("unconditional form not executed"); // RULE2

   property p_size;
      instr_valid_in && f_var == CMID_VAR_C |=> size_out == CMID_SZ_16;
   endproperty
   a_size: assert property (p_size) else $error("short form size wrong"); // RULE3

   property p_gen1;
      instr_valid_in |=> dm_index_out == {1'b0, $past(instr_word_in[CMID_F_G1I +: 3])};
   endproperty
   a_gen1: assert property (p_gen1) else $error("first index select wrong"); // RULE4

   property p_gen2;
      instr_valid_in |=> pm_modify_out == {1'b1, $past(instr_word_in[CMID_F_G2M +: 3])};
   endproperty
   a_gen2: assert property (p_gen2) else $error("second modify select wrong"); // RULE7

   property p_bcast;
      instr_valid_in && mode_in == CMID_BCAST |=> y_incr_out == 2'h0;
   endproperty
   a_bcast: assert property (p_bcast) else $error("broadcast offset not zero"); // RULE21

   property p_wb_gate;
      valid_out && !exec_out |-> !wb_dm_out && !wb_pm_out;
   endproperty
   a_wb_gate: assert property (p_wb_gate) else $error("write-back without execution"); // RULE23

   property p_illegal;
      instr_valid_in && !legal |=> illegal_out && !exec_out && !dm_en_out && !pm_en_out;
   endproperty
   a_illegal: assert property (p_illegal) else $error("unlisted encoding not blocked"); // RULE22

   property p_form1b;
      instr_valid_in && f_form == CMID_FORM1 && f_var == CMID_VAR_B |=> !compute_en_out;
   endproperty
   a_form1b: assert property (p_form1b) else $error("form 1b computed"); // RULE14

   property p_pre;
      pre_mod_out |-> !wb_dm_out && !wb_pm_out;
   endproperty
   a_pre: assert property (p_pre) else $error("pre-modify wrote back"); // RULE20

   property p_gen1_mod;
      instr_valid_in |=> dm_modify_out == {1'b0, $past(instr_word_in[CMID_F_G1M +: 3])};
   endproperty
   a_gen1_mod: assert property (p_gen1_mod) else $error("first modify select wrong"); // RULE5

   property p_gen2_idx;
      instr_valid_in |=> pm_index_out == {1'b1, $past(instr_word_in[CMID_F_G2I +: 3])};
   endproperty
   a_gen2_idx: assert property (p_gen2_idx) else $error("second index select wrong"); // RULE6

   property p_dreg;
      instr_valid_in |=> dreg_a_out == $past(instr_word_in[CMID_F_DRA +: 4])
                         && dreg_b_out == $past(instr_word_in[CMID_F_DRB +: 4]);
   endproperty
   a_dreg: assert property (p_dreg) else $error("data register numbers wrong"); // RULE8 RULE9

   property p_simd;
      instr_valid_in && mode_in == CMID_SIMD && !short_word_in |=> y_incr_out == CMID_YINC_NORM;
   endproperty
   a_simd: assert property (p_simd) else $error("second element offset wrong"); // RULE11

   property p_long;
      go && f_form == CMID_FORM3 && f_long |=> long_word_out;
   endproperty
   a_long: assert property (p_long) else $error("long word qualifier ignored"); // RULE10

   property p_imm;
      go && f_form == CMID_FORM4 |=> imm_mod_en_out && imm_mod_out == $past(instr_word_in[CMID_F_IMM +: 6]);
   endproperty
   a_imm: assert property (p_imm) else $error("immediate modifier wrong"); // RULE16

   property p_swap;
      go && f_form == CMID_FORM5 && instr_word_in[CMID_F_SWAP] |=> swap_out && !reg_move_out;
   endproperty
   a_swap: assert property (p_swap) else $error("register swap not issued"); // RULE17

   property p_shift;
      go && f_form == CMID_FORM6 |=> shift_imm_en_out && !compute_en_out;
   endproperty
   a_shift: assert property (p_shift) else $error("shift immediate not issued"); // RULE18

   property p_dual;
      go && f_form == CMID_FORM1 |=> dm_en_out && pm_en_out && wb_dm_out && wb_pm_out;
   endproperty
   a_dual: assert property (p_dual) else $error("dual move not issued"); // RULE13

   c_dual: cover property (exec_out && dm_en_out && pm_en_out);
   c_swap: cover property (exec_out && swap_out);
   c_simd: cover property (exec_out && y_incr_out == CMID_YINC_SHORT);
   c_bad:  cover property (illegal_out);
   c_imm:  cover property (exec_out && imm_mod_en_out);

endmodule

`default_nettype wire

/* cmid_pkg.sv */
// Constants and types for the group-one compute/move instruction decoder.
// Assumes the fetch stage hands over one pre-aligned instruction word per strobe.
package cmid_pkg;

   // Instruction word width as delivered by fetch (short forms left aligned)
   localparam int CMID_WORD_W = 48;

   // Field positions inside the delivered word (lsb of each field)
   localparam int CMID_F_FORM    = 45;  // 3 bits, form 1..7
   localparam int CMID_F_VAR     = 43;  // 2 bits, 0=a 1=b 2=c
   localparam int CMID_F_CONDP   = 42;  // condition present
   localparam int CMID_F_COMPP   = 41;  // compute present
   localparam int CMID_F_DMWR    = 40;  // data port: 1 = register to memory
   localparam int CMID_F_PMWR    = 39;  // program port: 1 = register to memory
   localparam int CMID_F_SELPM   = 38;  // single move/modify uses second generator
   localparam int CMID_F_PRE     = 37;  // modify operand written before index
   localparam int CMID_F_LONG    = 36;  // long word qualifier
   localparam int CMID_F_G1I     = 33;  // 3 bits
   localparam int CMID_F_G1M     = 30;  // 3 bits
   localparam int CMID_F_G2I     = 27;  // 3 bits
   localparam int CMID_F_G2M     = 24;  // 3 bits
   localparam int CMID_F_DRA     = 20;  // 4 bits
   localparam int CMID_F_DRB     = 16;  // 4 bits
   localparam int CMID_F_IMM     = 10;  // 6 bits
   localparam int CMID_F_SWAP    = 9;
   localparam int CMID_F_IWR     = 8;

   // Form codes
   localparam logic [2:0] CMID_FORM1 = 3'h1;
   localparam logic [2:0] CMID_FORM2 = 3'h2;
   localparam logic [2:0] CMID_FORM3 = 3'h3;
   localparam logic [2:0] CMID_FORM4 = 3'h4;
   localparam logic [2:0] CMID_FORM5 = 3'h5;
   localparam logic [2:0] CMID_FORM6 = 3'h6;
   localparam logic [2:0] CMID_FORM7 = 3'h7;

   // Variant codes
   localparam logic [1:0] CMID_VAR_A = 2'h0;
   localparam logic [1:0] CMID_VAR_B = 2'h1;
   localparam logic [1:0] CMID_VAR_C = 2'h2;

   // Second element increments for normal and short word access
   localparam logic [1:0] CMID_YINC_NORM  = 2'h1;
   localparam logic [1:0] CMID_YINC_SHORT = 2'h2;

   typedef enum logic [1:0] {CMID_SZ_NONE, CMID_SZ_48, CMID_SZ_32, CMID_SZ_16} cmid_size_e;
   typedef enum logic [1:0] {CMID_SISD, CMID_SIMD, CMID_BCAST} cmid_mode_e;

   typedef struct packed {
      logic       valid;
      logic       exec;
      logic       illegal;
      cmid_size_e size;
      logic       compute_en;
      logic       shift_imm_en;
      logic       dm_en;
      logic       dm_wr;
      logic       pm_en;
      logic       pm_wr;
      logic [3:0] dm_index;
      logic [3:0] dm_modify;
      logic [3:0] pm_index;
      logic [3:0] pm_modify;
      logic [3:0] dreg_a;
      logic [3:0] dreg_b;
      logic [1:0] y_incr;
      logic       long_word;
      logic       pre_mod;
      logic       wb_dm;
      logic       wb_pm;
      logic       imm_mod_en;
      logic [5:0] imm_mod;
      logic       reg_move;
      logic       swap;
      logic       index_write;
   } cmid_state_s;

   localparam cmid_state_s CMID_STATE_RST = '0;

endpackage

/* cmid_agen_model.sv */
// Address generator stand-in: counts executed memory transfers and index updates.
// Assumes the decoder's controls stand one cycle each, sampled on the rising clock.
`timescale 1ns/100ps
`default_nettype none
module cmid_agen_model (
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       sys_rst_in,
   // Decoded controls
   input  wire logic       dm_en_in,
   input  wire logic       pm_en_in,
   input  wire logic       wb_dm_in,
   input  wire logic       wb_pm_in,
   // Running counts
   output logic [7:0]      xfer_cnt_out,
   output logic [7:0]      wb_cnt_out
);
   // transfer and update count
   // Only counts are kept; memory contents are left out to keep the model small
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         xfer_cnt_out <= 8'h00;
         wb_cnt_out   <= 8'h00;
      end else begin
         xfer_cnt_out <= xfer_cnt_out + 8'(dm_en_in) + 8'(pm_en_in);
         wb_cnt_out   <= wb_cnt_out + 8'(wb_dm_in) + 8'(wb_pm_in);
      end
   end
endmodule
`default_nettype wire

/* tb_compute_move_instr_decode.sv */
// Self-checking bench for the group-one decoder with an address generator model.
// Assumes outputs stand in the cycle after the strobe; inputs change on falling edges.
`timescale 1ns/100ps
`default_nettype none
module tb_compute_move_instr_decode;
   import cmid_pkg::*;
   typedef struct packed {
      logic [2:0]  form;
      logic [1:0]  vari;
      logic [8:0]  flags;
      logic        cond;
      cmid_mode_e  mode;
      logic        short_w;
      cmid_size_e  size;
      logic [15:0] exp_v;
   } cmid_row_s;
   // Flags: cond comp dmwr pmwr sel pre lw swap iwr
   localparam int NR = 17;
   localparam cmid_row_s ROWS [NR] = '{
      '{3'h1, 2'h0, 9'h1C0, 1'b1, CMID_SISD,  1'b0, CMID_SZ_48, 16'h6EC0},
      '{3'h1, 2'h0, 9'h1C0, 1'b0, CMID_SISD,  1'b0, CMID_SZ_48, 16'h0000},
      '{3'h1, 2'h0, 9'h0A0, 1'b0, CMID_SISD,  1'b0, CMID_SZ_48, 16'h6BC0},
      '{3'h1, 2'h1, 9'h040, 1'b1, CMID_SIMD,  1'b0, CMID_SZ_32, 16'h4EC1},
      '{3'h3, 2'h2, 9'h000, 1'b0, CMID_SISD,  1'b0, CMID_SZ_16, 16'h4880},
      '{3'h3, 2'h0, 9'h1DC, 1'b1, CMID_SIMD,  1'b1, CMID_SZ_48, 16'h6322},
      '{3'h3, 2'h0, 9'h1DC, 1'b0, CMID_BCAST, 1'b0, CMID_SZ_48, 16'h0000},
      '{3'h4, 2'h1, 9'h108, 1'b1, CMID_SISD,  1'b0, CMID_SZ_32, 16'h4810},
      '{3'h5, 2'h0, 9'h180, 1'b1, CMID_SISD,  1'b0, CMID_SZ_48, 16'h6008},
      '{3'h6, 2'h0, 9'h140, 1'b1, CMID_SIMD,  1'b0, CMID_SZ_48, 16'h5C81},
      '{3'h7, 2'h0, 9'h190, 1'b1, CMID_SISD,  1'b0, CMID_SZ_48, 16'h6040},
      '{3'h7, 2'h1, 9'h101, 1'b1, CMID_SISD,  1'b0, CMID_SZ_32, 16'h4004},
      '{3'h2, 2'h2, 9'h080, 1'b0, CMID_SISD,  1'b0, CMID_SZ_16, 16'h6000},
      '{3'h6, 2'h1, 9'h100, 1'b1, CMID_SISD,  1'b0, CMID_SZ_NONE, 16'h8000},
      '{3'h1, 2'h3, 9'h080, 1'b1, CMID_SISD,  1'b0, CMID_SZ_NONE, 16'h8000},
      '{3'h1, 2'h1, 9'h080, 1'b1, CMID_SISD,  1'b0, CMID_SZ_NONE, 16'h8000},
      '{3'h3, 2'h2, 9'h100, 1'b1, CMID_SISD,  1'b0, CMID_SZ_NONE, 16'h8000}};
   // Stimulus
   logic                   clk_in = 1'b0;
   logic                   sys_rst_in = 1'b1;
   logic                   instr_valid_in = 1'b0;
   logic [CMID_WORD_W-1:0] instr_word_in = '0;
   logic                   cond_true_in = 1'b0;
   cmid_mode_e             mode_in = CMID_SISD;
   logic                   short_word_in = 1'b0;
   // Observed
   logic                   valid_out, exec_out, illegal_out, compute_en_out, shift_imm_en_out;
   logic                   dm_en_out, dm_wr_out, pm_en_out, pm_wr_out, long_word_out, pre_mod_out;
   logic                   wb_dm_out, wb_pm_out, imm_mod_en_out, reg_move_out, swap_out, index_write_out;
   cmid_size_e             size_out;
   logic [3:0]             dm_index_out, dm_modify_out, pm_index_out, pm_modify_out, dreg_a_out, dreg_b_out;
   logic [5:0]             imm_mod_out;
   logic [1:0]             y_incr_out;
   logic [7:0]             xfer_cnt, wb_cnt, nx, nwb;
   int                     n_errors = 0;
   int                     checked = 0;
   int                     cycles = 0;
   cmid_row_s              r;
   logic [CMID_WORD_W-1:0] w;
   logic [1:0]             ps;

   cmid_decode DUT (.clk_in, .sys_rst_in, .instr_valid_in, .instr_word_in, .cond_true_in, .mode_in,
      .short_word_in, .valid_out, .exec_out, .illegal_out, .size_out, .compute_en_out, .shift_imm_en_out,
      .dm_en_out, .dm_wr_out, .pm_en_out, .pm_wr_out, .dm_index_out, .dm_modify_out, .pm_index_out,
      .pm_modify_out, .long_word_out, .pre_mod_out, .wb_dm_out, .wb_pm_out, .imm_mod_en_out, .imm_mod_out,
      .dreg_a_out, .dreg_b_out, .y_incr_out, .reg_move_out, .swap_out, .index_write_out);
   cmid_agen_model AGEN (.clk_in, .sys_rst_in, .dm_en_in(dm_en_out), .pm_en_in(pm_en_out),
      .wb_dm_in(wb_dm_out), .wb_pm_in(wb_pm_out), .xfer_cnt_out(xfer_cnt), .wb_cnt_out(wb_cnt));

   // Clock at 25 MHz
   always #20 clk_in = ~clk_in;
   // Hang guard, well above the roughly 45 cycles the tests need
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 2000) begin
         n_errors++;
         end_sim();
      end
   end

   function automatic logic [15:0] flags_now();
      return {illegal_out, exec_out, compute_en_out, shift_imm_en_out, dm_en_out, dm_wr_out, pm_en_out,
              pm_wr_out, wb_dm_out, wb_pm_out, long_word_out, imm_mod_en_out, reg_move_out,
              index_write_out, y_incr_out};
   endfunction
   task automatic cmp_flags(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_field(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Called at a falling edge; presents one word and waits until its answer stands
   task automatic drive(input logic [CMID_WORD_W-1:0] word, input logic cnd, input cmid_mode_e md,
                        input logic sh);
      instr_valid_in = 1'b1;
      instr_word_in  = word;
      cond_true_in   = cnd;
      mode_in        = md;
      short_word_in  = sh;
      @(negedge clk_in);
   endtask
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      nx  = 8'h00;
      nwb = 8'h00;
      // A word offered during reset must not leave the outputs
      repeat (8) @(negedge clk_in);
      drive({3'h1, 2'h0, 43'h0}, 1'b1, CMID_SISD, 1'b0);
      instr_valid_in = 1'b0;
      @(negedge clk_in);
      cmp_flags(flags_now(), 16'h0000);
      cmp_field({31'h0, valid_out}, 32'h0);
      repeat (6) @(negedge clk_in);
      sys_rst_in = 1'b0;
      $display("Reset test done");
      @(negedge clk_in);
      // Table rows, sent back to back every cycle
      for (int i = 0; i < NR; i++) begin
         r = ROWS[i];
         w = '0;
         w[CMID_F_FORM +: 3]  = r.form;
         w[CMID_F_VAR +: 2]   = r.vari;
         w[CMID_F_CONDP -: 7] = r.flags[8:2];
         w[CMID_F_SWAP -: 2]  = r.flags[1:0];
         w[CMID_F_G1I +: 3]   = 3'(i);
         w[CMID_F_G1M +: 3]   = 3'(i + 1);
         w[CMID_F_G2I +: 3]   = 3'(i + 2);
         w[CMID_F_G2M +: 3]   = 3'(i + 5);
         w[CMID_F_DRA +: 4]   = 4'(i);
         w[CMID_F_DRB +: 4]   = 4'(15 - i);
         w[CMID_F_IMM +: 6]   = 6'(i * 7 + 3);
         drive(w, r.cond, r.mode, r.short_w);
         cmp_flags(flags_now(), r.exp_v);
         cmp_field({7'h00, valid_out, dm_index_out, dm_modify_out, pm_index_out, pm_modify_out, dreg_a_out,
                    dreg_b_out}, {7'h00, 1'b1, 4'(i % 8), 4'((i + 1) % 8), 4'(8 + (i + 2) % 8),
                    4'(8 + (i + 5) % 8), 4'(i), 4'(15 - i)});
         if (!r.exp_v[15]) cmp_field({30'h0, size_out}, {30'h0, r.size});
         if (r.exp_v[4]) cmp_field({26'h0, imm_mod_out}, 32'((i * 7 + 3) % 64));
         // Pre-modify only on executed forms 3 and 4; swap only on executed form 5
         ps = {r.flags[3] && r.exp_v[14] && (r.form == 3'h3 || r.form == 3'h4),
               r.flags[1] && r.exp_v[14] && r.form == 3'h5};
         cmp_field({30'h0, pre_mod_out, swap_out}, {30'h0, ps});
         nx  = nx + 8'(r.exp_v[11]) + 8'(r.exp_v[9]);
         nwb = nwb + 8'(r.exp_v[7]) + 8'(r.exp_v[6]);
      end
      instr_valid_in = 1'b0;
      @(negedge clk_in);
      cmp_flags(flags_now(), 16'h0000);
      cmp_field({31'h0, valid_out}, 32'h0);
      cmp_field({16'h0, xfer_cnt, wb_cnt}, {16'h0, nx, nwb});
      $display("Row test done");
      // Swap with the complementary register, then the same word with a false condition
      drive({3'h5, 2'h0, 1'b1, 32'h0, 1'b1, 9'h000}, 1'b1, CMID_SISD, 1'b0);
      cmp_flags(flags_now(), 16'h4000);
      cmp_field({30'h0, pre_mod_out, swap_out}, 32'h1);
      drive({3'h5, 2'h0, 1'b1, 32'h0, 1'b1, 9'h000}, 1'b0, CMID_SISD, 1'b0);
      instr_valid_in = 1'b0;
      cmp_field({30'h0, pre_mod_out, swap_out}, 32'h0);
      @(negedge clk_in);
      $display("Swap test done");
      // Reset in mid-run clears a standing answer at once
      drive({3'h1, 2'h0, 1'b1, 1'b1, 1'b1, 40'h0}, 1'b1, CMID_SISD, 1'b0);
      instr_valid_in = 1'b0;
      sys_rst_in     = 1'b1;
      #1;
      cmp_flags(flags_now(), 16'h0000);
      repeat (2) @(negedge clk_in);
      sys_rst_in = 1'b0;
      @(negedge clk_in);
      drive({3'h1, 2'h0, 1'b1, 1'b1, 1'b1, 40'h0}, 1'b1, CMID_SISD, 1'b0);
      instr_valid_in = 1'b0;
      cmp_flags(flags_now(), 16'h6EC0);
      $display("Mid-run reset test done");
      end_sim();
   end
endmodule
`default_nettype wire
